/* File: src/dtu_apb.sv */
// apb slave decode for the debug trigger unit
module dtu_apb
    import dtu_pkg::*;
(
    input  wire logic        psel,     // select
    input  wire logic        penable,  // access phase
    input  wire logic        pwrite,   // direction
    input  wire logic [7:0]  paddr,    // byte address
    output logic             wr_go,    // write takes effect
    output logic             rd_go,    // read taken
    output logic [5:0]       widx,     // word index
    output logic             unmapped  // no register at address
);
    // one-cycle access phase, pready registered in dtu_top one cycle after setup
    assign wr_go = psel && penable && pwrite;
    assign rd_go = psel && penable && !pwrite;
    assign widx  = paddr[7:2];
    // decode known offsets
    always_comb begin
        case (paddr)
            DTU_CTRL_OFS, DTU_RANGE_OFS, DTU_STATUS_OFS, DTU_CLEAR_OFS, DTU_IRQEN_OFS,
            DTU_ACTL_OFS, DTU_AADDR_OFS, DTU_ADATA_OFS, DTU_AMASK_OFS,
            DTU_BCTL_OFS, DTU_BADDR_OFS, DTU_DCTL_OFS, DTU_DADDR_OFS: unmapped = 1'b0;
            default: unmapped = 1'b1;
        endcase
    end
endmodule // dtu_apb

/* File: src/dtu_cmp.sv */
// one address comparator with optional masked data compare
module dtu_cmp
    import dtu_pkg::*;
#(
    parameter bit HAS_DATA = 1'b0
) (
    input  wire logic [31:0] ctl,       // comparator control
    input  wire logic [23:0] addr_ref,  // stored address
    input  wire logic [31:0] data_ref,  // stored data
    input  wire logic [31:0] data_msk,  // 1 = bit compared
    input  wire logic        opc_vld,   // opcode reaching execute
    input  wire logic [23:0] opc_pc,    // its address
    input  wire logic        acc_vld,   // data access strobe
    input  wire logic [23:0] acc_addr,  // data access address
    input  wire logic [31:0] acc_data,  // data access data
    input  wire logic        acc_rd,    // 1 read, 0 write
    output logic             hit,       // exact match this cycle
    output logic             qual       // access qualifies for range
);
    logic dir_ok;  // direction qualification
    logic dat_ok;  // masked data compare
    // direction qualify: 0 writes, 1 reads
    assign dir_ok = !ctl[CC_QUAL_BIT] || (ctl[CC_DIR_BIT] == acc_rd);
    assign dat_ok = !HAS_DATA || (((acc_data ^ data_ref) & data_msk) == 32'h0);
    // opcode mode ignores data and direction
    always_comb begin
        if (!ctl[CC_EN_BIT]) begin
            hit  = 1'b0;
            qual = 1'b0;
        end else if (ctl[CC_OPC_BIT]) begin
            hit  = opc_vld && (opc_pc == addr_ref);
            qual = opc_vld;
        end else begin
            hit  = acc_vld && (acc_addr == addr_ref) && dir_ok && dat_ok;
            qual = acc_vld && dir_ok;
        end
    end
endmodule // dtu_cmp

/* File: src/dtu_pkg.sv */
// package with register map, field positions and enumerations of the debug trigger unit
//
// Contract
// - three comparators compare address with pc or data
// - comparator a also compares masked data bus; range modes here ignore its data and mask, qualifying on direction only
// - exact or range match, range from range control
// - qualify enabled: direction must equal selection
// - opcode mode ignores data, mask and direction
// - opcode mode cleared: match data access addresses
// - any match can move sequencer to chosen state
// - no recheck of original match condition later
// - match0,1,3 from a,b,d outside range modes
// - resume at breakpoint address fires again, disarms
// - match at swi vector may double interrupt
// - background entry and commands leave unit untouched
// - select 0 writes only, select 1 reads only
// - stored address bits equal bus bits
// - final state breakpoint, return to state 0
// - address registers writable only while disarmed
package dtu_pkg;
    // register byte offsets
    localparam logic [7:0] DTU_CTRL_OFS    = 8'h00; // arm, manual trigger, state
    localparam logic [7:0] DTU_RANGE_OFS   = 8'h04; // range control register
    localparam logic [7:0] DTU_STATUS_OFS  = 8'h08; // sticky event flags (ro)
    localparam logic [7:0] DTU_CLEAR_OFS   = 8'h0c; // write one to clear (wo)
    localparam logic [7:0] DTU_IRQEN_OFS   = 8'h10; // interrupt enable
    localparam logic [7:0] DTU_ACTL_OFS    = 8'h20; // comparator a control
    localparam logic [7:0] DTU_AADDR_OFS   = 8'h24; // comparator a address
    localparam logic [7:0] DTU_ADATA_OFS   = 8'h28; // comparator a data bytes
    localparam logic [7:0] DTU_AMASK_OFS   = 8'h2c; // comparator a data mask
    localparam logic [7:0] DTU_BCTL_OFS    = 8'h30; // comparator b control
    localparam logic [7:0] DTU_BADDR_OFS   = 8'h34; // comparator b address
    localparam logic [7:0] DTU_DCTL_OFS    = 8'h40; // comparator d control
    localparam logic [7:0] DTU_DADDR_OFS   = 8'h44; // comparator d address
    // comparator control fields
    localparam int CC_QUAL_BIT = 0;   // access type qualify
    localparam int CC_DIR_BIT  = 1;   // direction select, 1 read
    localparam int CC_OPC_BIT  = 2;   // opcode address match
    localparam int CC_EN_BIT   = 3;   // comparator enable
    localparam int CC_NXT_LSB  = 4;   // next state field, 2 bits
    // control register fields
    localparam int CR_ARM_BIT  = 0;   // arm
    localparam int CR_MANUAL_TRIGGER_BIT_BIT = 1;   // manual trigger bit (self clearing)
    localparam int CR_ST_LSB   = 4;   // sequencer state (ro), 2 bits
    // range control values
    localparam logic [1:0] RNG_OFF     = 2'h0; // simple matches
    localparam logic [1:0] RNG_INSIDE  = 2'h1; // a <= addr <= b
    localparam logic [1:0] RNG_OUTSIDE = 2'h2; // addr < a or addr > b
    // status bits
    localparam int ST_MA  = 0;  // match 0
    localparam int ST_MB  = 1;  // match 1
    localparam int ST_MD  = 2;  // match 3
    localparam int ST_BRK = 3;  // breakpoint
    localparam int NEV    = 4;  // event count
    // reset values
    localparam logic [31:0] DTU_RST = 32'h0000_0000;
    localparam logic [3:0]  FINAL_NEXT = 4'h0; // next-state code for final
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_S1, SEQ_S2, SEQ_S3} dtu_seq_e;
endpackage

/* File: src/dtu_top.sv */
// debug trigger unit: three comparators, sequencer, apb registers, interrupt
//
// Chosen here: the register addresses and the APB interface to the registers.
module dtu_top
    import dtu_pkg::*;
(
    input  wire logic        pclk,       // bus clock
    input  wire logic        presetn,    // async reset, low
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb enable
    input  wire logic        pwrite,     // apb write
    input  wire logic [7:0]  paddr,      // apb address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic [31:0]      prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error
    input  wire logic        opc_vld,    // opcode reaching execute
    input  wire logic [23:0] opc_pc,     // its address
    input  wire logic        acc_vld,    // data access strobe
    input  wire logic [23:0] acc_addr,   // data access address
    input  wire logic [31:0] acc_data,   // data access data
    input  wire logic        acc_rd,     // 1 read, 0 write
    input  wire logic        bg_entry,   // background entry or command
    output logic             match0_q,   // match 0 pulse
    output logic             match1_q,   // match 1 pulse
    output logic             match3_q,   // match 3 pulse
    output logic             brk_q,      // breakpoint pulse
    output logic             armed_q,    // unit armed
    output logic             irq_q       // level interrupt
);
    // configuration registers
    logic [31:0] actl_q, bctl_q, dctl_q;  // comparator controls
    logic [23:0] aadr_q, badr_q, dadr_q;  // comparator addresses
    logic [31:0] adat_q, amsk_q;          // comparator a data and mask
    logic [1:0]  rng_q;                   // range mode
    logic [NEV-1:0] sts_q, ien_q;         // status and enable
    dtu_seq_e    seq_q;                   // sequencer state
    logic        manual_trigger_bit_q;                  // manual trigger request
    // bus decode
    logic wr_go, rd_go, unmapped;
    logic [5:0] widx;
    logic hit_a, hit_b, hit_d, q_a, q_b, q_d;
    logic in_rng, m0, m1, m3, fire;
    logic [1:0] nxt;
    logic [NEV-1:0] ev;
    logic [31:0] rd_d;

    dtu_apb u_apb (
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .wr_go    (wr_go),
        .rd_go    (rd_go),
        .widx     (widx),
        .unmapped (unmapped)
    );

    // comparator a with data compare
    dtu_cmp #(.HAS_DATA(1'b1)) u_cmp_a (
        .ctl(actl_q), .addr_ref(aadr_q), .data_ref(adat_q), .data_msk(amsk_q),
        .opc_vld(opc_vld), .opc_pc(opc_pc), .acc_vld(acc_vld), .acc_addr(acc_addr),
        .acc_data(acc_data), .acc_rd(acc_rd), .hit(hit_a), .qual(q_a)
    );
    // comparator b, address only
    dtu_cmp #(.HAS_DATA(1'b0)) u_cmp_b (
        .ctl(bctl_q), .addr_ref(badr_q), .data_ref(32'h0), .data_msk(32'h0),
        .opc_vld(opc_vld), .opc_pc(opc_pc), .acc_vld(acc_vld), .acc_addr(acc_addr),
        .acc_data(acc_data), .acc_rd(acc_rd), .hit(hit_b), .qual(q_b)
    );
    // comparator d, address only
    dtu_cmp #(.HAS_DATA(1'b0)) u_cmp_d (
        .ctl(dctl_q), .addr_ref(dadr_q), .data_ref(32'h0), .data_msk(32'h0),
        .opc_vld(opc_vld), .opc_pc(opc_pc), .acc_vld(acc_vld), .acc_addr(acc_addr),
        .acc_data(acc_data), .acc_rd(acc_rd), .hit(hit_d), .qual(q_d)
    );

    // match mapping, range pairs a with b on match 0
    always_comb begin
        logic [23:0] ca;
        ca     = actl_q[CC_OPC_BIT] ? opc_pc : acc_addr;
        in_rng = (ca >= aadr_q) && (ca <= badr_q);
        case (rng_q)
            RNG_INSIDE: begin
                m0 = q_a && in_rng;
                m1 = 1'b0;
            end
            RNG_OUTSIDE: begin
                m0 = q_a && !in_rng;
                m1 = 1'b0;
            end
            default: begin
                m0 = hit_a;
                m1 = hit_b;
            end
        endcase
        m3 = hit_d;
    end

    // next state from highest-priority match, manual trigger first
    always_comb begin
        fire = armed_q && (manual_trigger_bit_q || m0 || m1 || m3);
        if (manual_trigger_bit_q)  nxt = 2'h0;
        else if (m0) nxt = actl_q[CC_NXT_LSB +: 2];
        else if (m1) nxt = bctl_q[CC_NXT_LSB +: 2];
        else         nxt = dctl_q[CC_NXT_LSB +: 2];
    end

    // match outputs pulse once per qualifying access, no memory of past data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match0_q <= 1'b0;
            match1_q <= 1'b0;
            match3_q <= 1'b0;
        end else begin
            match0_q <= armed_q && m0;
            match1_q <= armed_q && m1;
            match3_q <= armed_q && m3;
        end
    end

    // sequencer; next code 0 means final: breakpoint and disarm on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q   <= SEQ_IDLE;
            armed_q <= 1'b0;
            brk_q   <= 1'b0;
        end else begin
            brk_q <= 1'b0;
            // bg_entry is deliberately not used here
            if (wr_go && widx == DTU_CTRL_OFS[7:2] && pwdata[CR_ARM_BIT] && !armed_q) begin
                armed_q <= 1'b1;
                seq_q   <= SEQ_S1;
            end else if (wr_go && widx == DTU_CTRL_OFS[7:2] && !pwdata[CR_ARM_BIT]) begin
                armed_q <= 1'b0;
                seq_q   <= SEQ_IDLE;
            end else if (fire) begin
                if ({2'h0, nxt} == FINAL_NEXT[3:0]) begin
                    brk_q   <= 1'b1;
                    armed_q <= 1'b0;
                    seq_q   <= SEQ_IDLE;
                end else begin
                    seq_q <= dtu_seq_e'(nxt);
                end
            end
        end
    end

    // manual trigger bit, self clearing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) manual_trigger_bit_q <= 1'b0;
        else          manual_trigger_bit_q <= wr_go && widx == DTU_CTRL_OFS[7:2] && pwdata[CR_MANUAL_TRIGGER_BIT_BIT]
                                && pwdata[CR_ARM_BIT] && armed_q;
    end

    // configuration writes; comparator registers only while disarmed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            actl_q <= DTU_RST; bctl_q <= DTU_RST; dctl_q <= DTU_RST;
            aadr_q <= DTU_RST[23:0]; badr_q <= DTU_RST[23:0]; dadr_q <= DTU_RST[23:0];
            adat_q <= DTU_RST; amsk_q <= DTU_RST;
            rng_q  <= DTU_RST[1:0];
            ien_q  <= DTU_RST[NEV-1:0];
        end else if (wr_go) begin
            if (widx == DTU_IRQEN_OFS[7:2]) ien_q <= pwdata[NEV-1:0];
            if (!armed_q) begin
                case (widx)
                    DTU_RANGE_OFS[7:2]: rng_q  <= pwdata[1:0];
                    DTU_ACTL_OFS[7:2]:  actl_q <= pwdata;
                    DTU_AADDR_OFS[7:2]: aadr_q <= pwdata[23:0];
                    DTU_ADATA_OFS[7:2]: adat_q <= pwdata;
                    DTU_AMASK_OFS[7:2]: amsk_q <= pwdata;
                    DTU_BCTL_OFS[7:2]:  bctl_q <= pwdata;
                    DTU_BADDR_OFS[7:2]: badr_q <= pwdata[23:0];
                    DTU_DCTL_OFS[7:2]:  dctl_q <= pwdata;
                    DTU_DADDR_OFS[7:2]: dadr_q <= pwdata[23:0];
                    default: ;
                endcase
            end
        end
    end

    // sticky status, set wins over clear
    assign ev = {brk_q, match3_q, match1_q, match0_q};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sts_q <= DTU_RST[NEV-1:0];
        else if (wr_go && widx == DTU_CLEAR_OFS[7:2]) sts_q <= (sts_q & ~pwdata[NEV-1:0]) | ev;
        else sts_q <= sts_q | ev;
    end

    // level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_q <= 1'b0;
        else          irq_q <= |(sts_q & ien_q);
    end

    // read mux
    always_comb begin
        case (widx)
            DTU_CTRL_OFS[7:2]:   rd_d = {26'h0, seq_q, 3'h0, armed_q};
            DTU_RANGE_OFS[7:2]:  rd_d = {30'h0, rng_q};
            DTU_STATUS_OFS[7:2]: rd_d = {28'h0, sts_q};
            DTU_IRQEN_OFS[7:2]:  rd_d = {28'h0, ien_q};
            DTU_ACTL_OFS[7:2]:   rd_d = actl_q;
            DTU_AADDR_OFS[7:2]:  rd_d = {8'h0, aadr_q};
            DTU_ADATA_OFS[7:2]:  rd_d = adat_q;
            DTU_AMASK_OFS[7:2]:  rd_d = amsk_q;
            DTU_BCTL_OFS[7:2]:   rd_d = bctl_q;
            DTU_BADDR_OFS[7:2]:  rd_d = {8'h0, badr_q};
            DTU_DCTL_OFS[7:2]:   rd_d = dctl_q;
            DTU_DADDR_OFS[7:2]:  rd_d = {8'h0, dadr_q};
            default:             rd_d = 32'h0;
        endcase
    end

    // apb answers: registered data and error, ready one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && unmapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_d : 32'h0;
        end
    end
    logic unused_rd;
    assign unused_rd = rd_go ^ bg_entry;
endmodule // dtu_top

/* File: test/dtu_cpu_model.sv */
// behavioural model of the cpu buses feeding the trigger unit
module dtu_cpu_model (
    input  wire logic   pclk,     // bus clock
    output logic        opc_vld,  // opcode at execute
    output logic [23:0] opc_pc,   // its address
    output logic        acc_vld,  // data access strobe
    output logic [23:0] acc_addr, // access address
    output logic [31:0] acc_data, // access data
    output logic        acc_rd    // 1 read
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle buses at time zero
    initial begin
        opc_vld = 1'b0;
        opc_pc = 24'h0;
        acc_vld = 1'b0;
        acc_addr = 24'h0;
        acc_data = 32'h0;
        acc_rd = 1'b0;
    end
    // one opcode for one cycle; pc is never advanced here, caller steps
    task automatic opcode(input logic [23:0] pc);
        @(posedge pclk);
        opc_vld <= 1'b1;
        opc_pc <= pc;
        @(posedge pclk);
        opc_vld <= 1'b0;
        opc_pc <= ~pc;
    endtask
    // one data access, lines inverted when released
    task automatic access(input logic [23:0] a, input logic [31:0] d, input logic r);
        @(posedge pclk);
        acc_vld <= 1'b1;
        acc_addr <= a;
        acc_data <= d;
        acc_rd <= r;
        @(posedge pclk);
        acc_vld <= 1'b0;
        acc_addr <= ~a;
        acc_data <= ~d;
        acc_rd <= ~r;
    endtask
endmodule // dtu_cpu_model

/* File: test/dtu_props.sv */
// port-level assertions for the debug trigger unit
module dtu_props (
    input wire logic pclk,     // bus clock
    input wire logic presetn,  // async reset, low
    input wire logic psel,     // apb select
    input wire logic penable,  // apb enable
    input wire logic pready,   // apb ready
    input wire logic pslverr,  // apb error
    input wire logic opc_vld,  // opcode strobe
    input wire logic acc_vld,  // data access strobe
    input wire logic bg_entry, // background entry
    input wire logic match0_q, // match 0 pulse
    input wire logic match1_q, // match 1 pulse
    input wire logic match3_q, // match 3 pulse
    input wire logic brk_q,    // breakpoint pulse
    input wire logic armed_q   // armed level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic any_m; // any match output
    assign any_m = match0_q || match1_q || match3_q;
    // a match needs an access or opcode one cycle earlier
    a_match_cause: assert property (any_m |-> $past(acc_vld) || $past(opc_vld))
        else $error("match without a bus access");
    // matches only come from an armed unit
    a_match_armed: assert property (any_m |-> $past(armed_q))
        else $error("match while disarmed");
    // one pulse per access
    a_match_single: assert property (match0_q && !acc_vld && !opc_vld |=> !match0_q)
        else $error("match held past one cycle");
    // breakpoint only from armed, then disarmed
    a_brk_armed: assert property (brk_q |-> $past(armed_q))
        else $error("breakpoint while disarmed");
    a_brk_disarm: assert property (brk_q |-> ##[0:1] !armed_q)
        else $error("breakpoint left unit armed");
    // background entry leaves arming alone
    // no bus write in this or the last cycle, so no manual trigger is pending
    a_bg_ignored: assert property (bg_entry && armed_q && !psel && !$past(psel)
        && !acc_vld && !opc_vld && !any_m |=> armed_q)
        else $error("background entry disarmed unit");
    // apb answers one cycle after setup
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    c_brk: cover property (brk_q);
    c_match: cover property (match0_q && armed_q);
    c_bg: cover property (bg_entry && armed_q);
    c_err: cover property (pslverr);
endmodule // dtu_props

/* File: test/tb_top.sv */
// self-checking testbench of the debug trigger unit
module tb_top;
    import dtu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, opc_vld, acc_vld, acc_rd;
    logic bg_entry, match0_q, match1_q, match3_q, brk_q, armed_q, irq_q, err, seen, r;
    logic [7:0]  paddr;   // apb address
    logic [31:0] pwdata, prdata, rv, d, adat, amsk; // bus words and stored data
    logic [23:0] opc_pc, acc_addr, a, aa, ba, da; // addresses
    logic [31:0] acc_data; // access data
    logic [2:0]  e;        // expected matches
    logic [3:0]  stat;     // expected status
    int fail_count, compares, i, k, st;
    logic op, adir;
    dtu_top dtu_top_opcode_address_match (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .opc_vld, .opc_pc, .acc_vld, .acc_addr, .acc_data, .acc_rd, .bg_entry,
        .match0_q, .match1_q, .match3_q, .brk_q, .armed_q, .irq_q);
    dtu_cpu_model cpu_opcode_address_match (.pclk, .opc_vld, .opc_pc, .acc_vld, .acc_addr, .acc_data, .acc_rd);
    always #20 pclk = ~pclk;
    // verdict and end of run
    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        compares++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    // apb transfer: setup, then access until ready
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for ready; only the watchdog ends a hung transfer
        do @(posedge pclk);
        while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, ad, 32'h0);
        chk("read", x & m, rv & m);
    endtask
    // one bus event and its match outputs
    task automatic acc(input logic [23:0] ad, input logic [31:0] dd, input logic rr,
                       input logic o, input logic [2:0] x);
        if (o) cpu_opcode_address_match.opcode(ad);
        else cpu_opcode_address_match.access(ad, dd, rr);
        #1 chk("match", {29'h0, x}, {29'h0, match3_q, match1_q, match0_q});
    endtask
    task automatic waitbrk;
        #1 seen = brk_q;
        repeat (3) begin
            @(posedge pclk);
            #1 seen |= brk_q;
        end
        chk("brk", 1, seen);
        chk("armed", 0, armed_q);
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, bg_entry, paddr, pwdata} = '0;
        void'($urandom(15));
        {aa, ba, da, amsk, stat} = {24'h123450, 24'h00a5c0, 24'h7f0010, 32'hffff, 4'h0};
        st = 1;
        adat = $urandom;
        adir = $urandom % 2;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(DTU_STATUS_OFS, 0, '1);
        rd(DTU_AADDR_OFS, 0, '1);
        rd(8'h3c, 0, '1);
        chk("slverr", 1, err);
        wr(DTU_ACTL_OFS, 32'h29 | adir << 1);
        wr(DTU_AADDR_OFS, aa);
        wr(DTU_ADATA_OFS, adat);
        wr(DTU_AMASK_OFS, amsk);
        wr(DTU_BCTL_OFS, 32'h38);
        wr(DTU_BADDR_OFS, ba);
        wr(DTU_DCTL_OFS, 32'h1c);
        wr(DTU_DADDR_OFS, da);
        wr(DTU_CTRL_OFS, 32'h1);
        for (i = 0; i < 60; i++) begin
            k = $urandom % 5;
            r = $urandom % 2;
            op = ($urandom % 3) == 0;
            a = k == 0 ? aa : k == 1 ? ba : k == 2 ? da : k == 3 ? aa ^ (1 << ($urandom % 24))
                : $urandom;
            d = ($urandom % 2) ? adat : adat ^ (1 << ($urandom % 32));
            e[0] = !op && a == aa && r == adir && ((d ^ adat) & amsk) == 0;
            e[1] = !op && a == ba;
            e[2] = op && a == da;
            acc(a, d, r, op, e);
            st = e[0] ? 2 : e[1] ? 3 : e[2] ? 1 : st;
            stat |= {1'b0, e};
        end
        rd(DTU_CTRL_OFS, st << 4, 32'h30);
        wr(DTU_AADDR_OFS, ~aa);
        rd(DTU_AADDR_OFS, aa, 32'hffffff);
        bg_entry <= 1'b1;
        repeat (3) @(posedge pclk);
        bg_entry <= 1'b0;
        #1 chk("armed", 1, armed_q);
        rd(DTU_STATUS_OFS, stat, 32'hf);
        chk("irq", 0, irq_q);
        wr(DTU_IRQEN_OFS, 32'hf);
        repeat (3) @(posedge pclk);
        #1 chk("irq", |stat, irq_q);
        wr(DTU_CLEAR_OFS, 32'hf);
        rd(DTU_STATUS_OFS, 0, 32'hf);
        chk("irq", 0, irq_q);
        wr(DTU_CTRL_OFS, 32'h3);
        waitbrk();
        rd(DTU_STATUS_OFS, 32'h8, 32'h8);
        wr(DTU_DCTL_OFS, 32'h0c);
        for (i = 0; i < 2; i++) begin
            wr(DTU_CTRL_OFS, 32'h1);
            acc(da, 0, 0, 1, 3'b100);
            waitbrk();
        end
        acc(da, 0, 0, 1, 3'b000);
        wr(DTU_CTRL_OFS, 32'h1);
        acc(da + 4, 0, 0, 1, 3'b000);
        chk("armed", 1, armed_q);
        wr(DTU_CTRL_OFS, 32'h0);
        // range modes: a is the lower and b the upper bound, match1 stays silent
        wr(DTU_AADDR_OFS, 32'h100);
        wr(DTU_BADDR_OFS, 32'h200);
        wr(DTU_ACTL_OFS, 32'h18);
        for (i = 1; i < 3; i++) begin
            wr(DTU_RANGE_OFS, i);
            wr(DTU_CTRL_OFS, 32'h1);
            acc(24'h200, 0, 0, 0, {2'b00, i == 1});
            acc(24'h201, 0, 1, 0, {2'b00, i == 2});
            wr(DTU_CTRL_OFS, 32'h0);
        end
        test_done();
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        test_done();
    end
endmodule // tb_top

bind dtu_top dtu_props dtu_props_opcode_address_match (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .opc_vld, .acc_vld, .bg_entry, .match0_q, .match1_q, .match3_q, .brk_q, .armed_q);
